/* File: cpu_move_mul_stack_call_ops.sv */
// Decode and execute of move, multiply, negate, stack and relative call instructions
`default_nettype none
module cpu_move_mul_stack_call_ops #(
  parameter int DATA_DEPTH  = cpu_ops_pkg::DATA_DEPTH,
  parameter int STACK_DEPTH = cpu_ops_pkg::STACK_DEPTH
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            instrValid,
  input  wire logic [15:0]                     instrWord,
  input  wire logic [cpu_ops_pkg::BANK_W-1:0]  bankSelect,
  input  wire logic                            loadEn,
  input  wire logic [cpu_ops_pkg::ADDR_W-1:0]  loadAddr,
  input  wire logic [7:0]                      loadData,
  output logic [1:0]                           qPhase,
  output logic                                 instrTaken,
  output logic [cpu_ops_pkg::PC_W-1:0]         programCounter,
  output logic [7:0]                           workingAccumulator,
  output logic [7:0]                           productHigh,
  output logic [7:0]                           productLow,
  output logic [cpu_ops_pkg::FLAG_W-1:0]       statusFlags,
  output logic [cpu_ops_pkg::PC_W-1:0]         returnStackTop,
  output logic [4:0]                           stackDepth,
  output logic                                 callFill,
  output logic                                 fileWriteStrobe,
  output logic [cpu_ops_pkg::ADDR_W-1:0]       fileWriteAddr,
  output logic [7:0]                           fileWriteData
);
  import cpu_ops_pkg::*;

  // Phase sequencer and instruction latch
  phase_t      phase;          // Current quarter of the instruction cycle
  phase_t      next_phase;
  logic [15:0] ir;             // Instruction word taken at Q1
  logic [15:0] next_ir;
  logic        irValid;        // A word was taken this cycle
  logic        next_irValid;
  logic        next_instrTaken;
  logic        next_callFill;

  // Architectural state
  logic [PC_W-1:0]   next_programCounter;
  logic [7:0]        next_workingAccumulator;
  logic [7:0]        next_productHigh;
  logic [7:0]        next_productLow;
  logic [FLAG_W-1:0] next_statusFlags;
  logic [PC_W-1:0]   next_returnStackTop;
  logic [4:0]        next_stackDepth;

  // File register write port
  logic              next_fileWriteStrobe;
  logic [ADDR_W-1:0] next_fileWriteAddr;
  logic [7:0]        next_fileWriteData;

  // Storage
  // Flip-flop arrays addressed by index; no reset so they stay plain registers
  logic [7:0]      dataMem [DATA_DEPTH];      // File registers
  logic [PC_W-1:0] stackMem [STACK_DEPTH];    // Return stack entries
  logic            memWrEn;
  logic [ADDR_W-1:0] memWrIdx;
  logic [7:0]      memWrData;
  logic            stackWrEn;
  logic [4:0]      stackWrIdx;
  logic [PC_W-1:0] stackWrData;

  // Decode helpers
  logic [ADDR_W-1:0] fileAddr;   // Resolved bank plus offset
  logic [7:0]        fileVal;    // Current contents of the addressed register
  logic [15:0]       product;
  logic [7:0]        negOut;
  logic [FLAG_W-1:0] negFlags;
  logic [7:0]        mulOperand; // Literal or file value feeding the multiplier
  logic [PC_W-1:0]   pcNext;     // Address of the following word
  logic [PC_W-1:0]   callOffset; // Twice the sign-extended offset
  logic              execute;    // Q4 of a real instruction cycle

  // One flag per instruction form of the latched word, plus two return stack level flags
  logic              isLoadLit;  // Load literal into the accumulator
  logic              isStore;    // Store accumulator into a file register
  logic              isMulLit;   // Multiply by literal
  logic              isMulFile;  // Multiply by file register
  logic              isNegate;   // Negate a file register
  logic              isPush;     // Push the counter
  logic              isPop;      // Pop the return stack
  logic              isCall;     // Relative call
  logic              stackRoom;  // Return stack can take another entry
  logic              stackAny;   // Return stack holds at least one entry

  // Bank bit set uses the bank select input; clear uses the access bank
  always_comb begin
    if (ir[8]) begin
      fileAddr = {bankSelect, ir[7:0]}; // [RULE_03]
    end else if (ir[7]) begin
      fileAddr = {ACCESS_HIGH_BANK, ir[7:0]}; // [RULE_03]
    end else begin
      fileAddr = {ACCESS_LOW_BANK, ir[7:0]}; // [RULE_03]
    end
  end

  // Reads are plain indexing; a shallower memory must cover the used range
  assign fileVal    = dataMem[fileAddr];
  assign pcNext     = programCounter + PC_STEP;
  assign callOffset = {{(PC_W-OFS_W-1){ir[OFS_W-1]}}, ir[OFS_W-1:0], 1'b0};
  assign execute    = (phase == PH_Q4) && irValid && !callFill;

  // Decode once from the latched word so that every consumer agrees on the form;
  // no-op words need no flag because they fall through to the default branch
  always_comb begin
    isLoadLit = (ir[15:8] == OP_LOAD_LIT);  // [RULE_01]
    isStore   = (ir[15:9] == OP_STORE_ACC); // [RULE_02]
    isMulLit  = (ir[15:8] == OP_MUL_LIT);   // [RULE_04]
    isMulFile = (ir[15:9] == OP_MUL_FILE);  // [RULE_07]
    isNegate  = (ir[15:9] == OP_NEGATE);    // [RULE_08]
    isPush    = (ir == OP_PUSH);            // [RULE_11]
    isPop     = (ir == OP_POP);             // [RULE_10]
    isCall    = (ir[15:11] == OP_REL_CALL); // [RULE_12]
    // A full stack drops the push but the counter still advances
    stackRoom = (stackDepth < 5'(STACK_DEPTH));
    stackAny  = (stackDepth != 5'd0);
  end

  // Literal multiply takes the low byte, file multiply the register
  always_comb begin
    if (isMulLit) begin
      mulOperand = ir[7:0];
    end else begin
      mulOperand = fileVal;
    end
  end

  mul_neg_unit u_mul_neg (
    .mulA     (workingAccumulator),
    .mulB     (mulOperand),
    .negIn    (fileVal),
    .product  (product),
    .negOut   (negOut),
    .negFlags (negFlags)
  );

  // Next-state logic for every register of the block
  // Results register at the edge that ends Q4, together with the write report,
  // so every result of one word appears at once; the bank select input is
  // sampled at that same edge, which means it must be settled by then.
  // Nothing here depends on an earlier word's results still being in flight.
  always_comb begin
    next_phase              = phase_t'(phase + 2'b01);
    next_ir                 = ir;
    next_irValid            = irValid;
    next_instrTaken         = 1'b0;
    next_callFill           = callFill;
    next_programCounter     = programCounter;
    next_workingAccumulator = workingAccumulator;
    next_productHigh        = productHigh;
    next_productLow         = productLow;
    next_statusFlags        = statusFlags;
    next_returnStackTop     = returnStackTop;
    next_stackDepth         = stackDepth;
    next_fileWriteStrobe    = 1'b0;
    next_fileWriteAddr      = fileWriteAddr;
    next_fileWriteData      = fileWriteData;
    memWrEn                 = 1'b0;
    memWrIdx                = loadAddr;
    memWrData               = loadData;
    stackWrEn               = 1'b0;
    stackWrIdx              = stackDepth;
    stackWrData             = pcNext;

    // Q1: take the word; during the call's idle cycle it is ignored
    // A word offered in any other phase is never looked at
    if (phase == PH_Q1) begin
      next_irValid    = instrValid && !callFill;
      next_ir         = instrWord;
      next_instrTaken = instrValid && !callFill;
    end

    // Q4 of the call's second cycle only ends the idle cycle
    if ((phase == PH_Q4) && callFill) begin
      next_callFill = 1'b0; // [RULE_14]
    end

    if (execute) begin
      // Every executed word except a relative call advances the counter by one word
      next_programCounter = pcNext;
      if (isLoadLit) begin
        next_workingAccumulator = ir[7:0]; // [RULE_01]
      end else if (isStore) begin
        // Write goes out at the same edge as the other results
        memWrEn   = 1'b1; // [RULE_02]
        memWrIdx  = fileAddr;
        memWrData = workingAccumulator;
      end else if (isMulLit || isMulFile) begin
        // Flags and both operands stay as they were
        next_productHigh = product[15:8]; // [RULE_05] [RULE_06]
        next_productLow  = product[7:0];  // [RULE_05]
      end else if (isNegate) begin
        // Result and flags both come from the negate adder
        memWrEn          = 1'b1; // [RULE_08]
        memWrIdx         = fileAddr;
        memWrData        = negOut;
        next_statusFlags = negFlags; // [RULE_08]
      end else if (isPush) begin
        // The word's own address goes on the stack
        if (stackRoom) begin
          stackWrEn           = 1'b1; // [RULE_11]
          stackWrData         = programCounter;
          next_returnStackTop = programCounter;
          next_stackDepth     = stackDepth + 5'd1;
        end
      end else if (isPop) begin
        // Entry one level down becomes the new top
        // An empty stack ignores the pop rather than wrapping
        if (stackAny) begin
          next_stackDepth = stackDepth - 5'd1; // [RULE_10]
          if (stackDepth >= 5'd2) begin
            next_returnStackTop = stackMem[stackDepth - 5'd2]; // [RULE_10]
          end else begin
            next_returnStackTop = PC_RESET;
          end
        end
      end else if (isCall) begin
        // Push the return address first, then jump relative to it
        // A full stack loses the return address but the jump still happens
        if (stackRoom) begin
          stackWrEn           = 1'b1; // [RULE_12]
          stackWrData         = pcNext;
          next_returnStackTop = pcNext;
          next_stackDepth     = stackDepth + 5'd1;
        end
        next_programCounter = pcNext + callOffset; // [RULE_13]
        next_callFill       = 1'b1;                 // [RULE_14]
      end else begin
        // Zero word, 1111 prefix and all words outside this group do nothing
        next_programCounter = pcNext; // [RULE_09]
      end
    end

    // The load port fills memory when no instruction writes this edge
    // A load that meets an instruction write is dropped, not retried,
    // so the host should preload only while no word is being executed
    if (!memWrEn && loadEn) begin
      memWrEn   = 1'b1;
      memWrIdx  = loadAddr;
      memWrData = loadData;
    end else if (memWrEn) begin
      next_fileWriteStrobe = 1'b1;
      next_fileWriteAddr   = memWrIdx;
      next_fileWriteData   = memWrData;
    end
  end

  // Control and architectural registers
  // Reset clears every visible output; storage keeps its contents
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase              <= PH_Q1;
      ir                 <= WORD_RESET;
      irValid            <= 1'b0;
      instrTaken         <= 1'b0;
      callFill           <= 1'b0;
      programCounter     <= PC_RESET;
      workingAccumulator <= BYTE_RESET;
      productHigh        <= BYTE_RESET;
      productLow         <= BYTE_RESET;
      statusFlags        <= FLAG_RESET;
      returnStackTop     <= PC_RESET;
      stackDepth         <= 5'd0;
      fileWriteStrobe    <= 1'b0;
      fileWriteAddr      <= '0;
      fileWriteData      <= BYTE_RESET;
    end else begin
      phase              <= next_phase;
      ir                 <= next_ir;
      irValid            <= next_irValid;
      instrTaken         <= next_instrTaken;
      callFill           <= next_callFill;
      programCounter     <= next_programCounter;
      workingAccumulator <= next_workingAccumulator;
      productHigh        <= next_productHigh;
      productLow         <= next_productLow;
      statusFlags        <= next_statusFlags;
      returnStackTop     <= next_returnStackTop;
      stackDepth         <= next_stackDepth;
      fileWriteStrobe    <= next_fileWriteStrobe;
      fileWriteAddr      <= next_fileWriteAddr;
      fileWriteData      <= next_fileWriteData;
    end
  end

  // Phase output mirrors the sequencer flop
  assign qPhase = phase;

  // Data storage is not reset; contents are undefined until written
  // Skipping the reset keeps thousands of flops off the reset tree; software
  // must write a register before it reads it back
  always_ff @(posedge clk) begin
    if (memWrEn) begin
      dataMem[memWrIdx] <= memWrData;
    end
    if (stackWrEn) begin
      stackMem[stackWrIdx] <= stackWrData;
    end
  end
endmodule
`default_nettype wire

/* File: cpu_ops_pkg.sv */
// Constants, opcode patterns and flag layout for the move/multiply/stack/call decoder
// What this block does
// [RULE_01] Load literal into accumulator, flags kept
// [RULE_02] Store accumulator into file register, flags kept
// [RULE_03] Bank bit picks bank select or access
// [RULE_04] Multiply accumulator by literal, accumulator kept
// [RULE_05] Product high and low bytes hold result
// [RULE_06] Multiplies touch no status flag
// [RULE_07] Multiply accumulator by file, operands kept
// [RULE_08] Negate file register, update five flags
// [RULE_09] Zero word and 1111 prefix are no-ops
// [RULE_10] Pop discards top of return stack
// [RULE_11] Push program counter onto return stack
// [RULE_12] Relative call pushes counter plus two
// [RULE_13] Call target is counter plus two plus 2n
// [RULE_14] Relative call takes two cycles, second idle
`default_nettype none
package cpu_ops_pkg;
  localparam int PC_W      = 21;             // Program counter width
  localparam int ADDR_W    = 12;             // File register address width
  localparam int BANK_W    = 4;              // Bank select width
  localparam int DATA_DEPTH = 4096;          // File register count
  localparam int STACK_DEPTH = 31;           // Return stack entries
  localparam int OFS_W     = 11;             // Relative call offset width
  // Opcode patterns, compared against the top bits of the word
  localparam logic [7:0]  OP_LOAD_LIT  = 8'h0E;    // Top byte of load literal
  localparam logic [7:0]  OP_MUL_LIT   = 8'h0D;    // Top byte of multiply literal
  localparam logic [6:0]  OP_STORE_ACC = 7'h37;    // Top seven bits of store
  localparam logic [6:0]  OP_NEGATE    = 7'h36;    // Top seven bits of negate
  localparam logic [6:0]  OP_MUL_FILE  = 7'h01;    // Top seven bits of multiply file
  localparam logic [4:0]  OP_REL_CALL  = 5'h1B;    // Top five bits of relative call
  localparam logic [3:0]  OP_NOP_HIGH  = 4'hF;     // Second-word no-op prefix
  localparam logic [15:0] OP_NOP_ZERO  = 16'h0000; // Default no-op word
  localparam logic [15:0] OP_PUSH      = 16'h0005; // Push word
  localparam logic [15:0] OP_POP       = 16'h0006; // Pop word
  // Access bank split: low half maps to bank 0, high half to the top bank
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  // Status flag bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;
  localparam int FLAG_W  = 5;
  // Reset values
  localparam logic [PC_W-1:0]   PC_RESET   = 21'h00_0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 21'h00_0002; // One word is two bytes
  localparam logic [7:0]        BYTE_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;
  localparam logic [15:0]       WORD_RESET = 16'h0000;
  // Four clock phases make one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;
endpackage
`default_nettype wire

/* File: mul_neg_unit.sv */
// Combinational unsigned multiplier and two's-complement negate with flags
`default_nettype none
module mul_neg_unit (
  input  wire logic [7:0]                   mulA,
  input  wire logic [7:0]                   mulB,
  input  wire logic [7:0]                   negIn,
  output logic [15:0]                       product,
  output logic [7:0]                        negOut,
  output logic [cpu_ops_pkg::FLAG_W-1:0]    negFlags
);
  import cpu_ops_pkg::*;

  logic [8:0] negSum;   // Inverted value plus one, with carry out
  logic [4:0] negLow;   // Low nibble sum, bit 4 is digit carry

  // Full 8x8 product, no overflow possible
  always_comb begin
    product = 16'({8'h00, mulA} * {8'h00, mulB}); // [RULE_04] [RULE_07]
  end

  // Negate as inverted operand plus one, so carries fall out of the adder
  always_comb begin
    negSum   = {1'b0, ~negIn} + 9'h001;            // [RULE_08]
    negLow   = {1'b0, ~negIn[3:0]} + 5'h01;
    negOut   = negSum[7:0];
    negFlags = FLAG_RESET;
    negFlags[FLAG_C]  = negSum[8];
    negFlags[FLAG_DC] = negLow[4];
    negFlags[FLAG_Z]  = (negSum[7:0] == 8'h00);
    // Only the most negative value overflows when negated
    negFlags[FLAG_OV] = (negIn == 8'h80);
    negFlags[FLAG_N]  = negSum[7];
  end
endmodule
`default_nettype wire

/* File: cpu_ops_asserts.sv */
// Concurrent checks on the decoder's instruction port, results and call fill
`default_nettype none
module cpu_ops_asserts
  import cpu_ops_pkg::*;
#(
  parameter int STACK_DEPTH = 31
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              instrValid,
  input wire logic [15:0]       instrWord,
  input wire logic [1:0]        qPhase,
  input wire logic              instrTaken,
  input wire logic [PC_W-1:0]   programCounter,
  input wire logic [7:0]        workingAccumulator,
  input wire logic [7:0]        productHigh,
  input wire logic [7:0]        productLow,
  input wire logic [FLAG_W-1:0] statusFlags,
  input wire logic [PC_W-1:0]   returnStackTop,
  input wire logic [4:0]        stackDepth,
  input wire logic              callFill,
  input wire logic              fileWriteStrobe,
  input wire logic [7:0]        fileWriteData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A word is accepted only at Q1 and never in the idle half of a call
  wire logic            take    = qPhase == 2'd0 && instrValid && !callFill;
  // Doubled, sign-extended call offset
  wire logic [PC_W-1:0] callOfs = {{(PC_W-12){instrWord[10]}}, instrWord[10:0], 1'b0};
  // Results land on the edge ending Q4, three edges after acceptance, so they are sampled four edges after it
  sequence fillRun;
    callFill [*4] ##1 !callFill;
  endsequence
  sequence takeMul;
    take && (instrWord[15:8] == OP_MUL_LIT || instrWord[15:9] == OP_MUL_FILE);
  endsequence
  AST_TAKE: assert property (take |=> instrTaken && qPhase == 2'd1)
    else $error("accepted word not acknowledged");
  AST_IDLE: assert property (!take |=> !instrTaken)
    else $error("acknowledge without an accepted word");
  AST_LOAD_LIT: assert property (take && instrWord[15:8] == OP_LOAD_LIT |-> ##4
    workingAccumulator == $past(instrWord[7:0], 4) && statusFlags == $past(statusFlags, 4))
    else $error("literal load wrong");
  AST_MUL_LIT: assert property (take && instrWord[15:8] == OP_MUL_LIT |-> ##4
    {productHigh, productLow} == 16'($past(workingAccumulator, 4)) * 16'($past(instrWord[7:0], 4)))
    else $error("literal product wrong");
  AST_MUL_KEEP: assert property (takeMul |-> ##4 statusFlags == $past(statusFlags, 4)
    && workingAccumulator == $past(workingAccumulator, 4))
    else $error("multiply altered flags or accumulator");
  AST_STORE: assert property (take && instrWord[15:9] == OP_STORE_ACC |-> ##4 fileWriteStrobe
    && fileWriteData == $past(workingAccumulator, 4) && statusFlags == $past(statusFlags, 4))
    else $error("store wrong");
  AST_NEG: assert property (take && instrWord[15:9] == OP_NEGATE |-> ##4 fileWriteStrobe
    && statusFlags[FLAG_Z] == (fileWriteData == 8'h00) && statusFlags[FLAG_N] == fileWriteData[7])
    else $error("negate flags wrong");
  AST_NOP: assert property (take && (instrWord == OP_NOP_ZERO || instrWord[15:12] == OP_NOP_HIGH) |-> ##4
    programCounter == $past(programCounter, 4) + PC_STEP && stackDepth == $past(stackDepth, 4))
    else $error("no-op changed state");
  AST_PUSH: assert property (take && instrWord == OP_PUSH && stackDepth < STACK_DEPTH |-> ##4
    returnStackTop == $past(programCounter, 4) && stackDepth == $past(stackDepth, 4) + 5'd1)
    else $error("push wrong");
  AST_POP: assert property (take && instrWord == OP_POP && stackDepth != 5'd0 |-> ##4
    stackDepth == $past(stackDepth, 4) - 5'd1)
    else $error("pop wrong");
  AST_CALL: assert property (take && instrWord[15:11] == OP_REL_CALL && stackDepth < STACK_DEPTH |-> ##4
    returnStackTop == $past(programCounter, 4) + PC_STEP
    && programCounter == $past(programCounter, 4) + PC_STEP + $past(callOfs, 4) ##0 fillRun)
    else $error("relative call wrong");
endmodule
bind cpu_move_mul_stack_call_ops cpu_ops_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_cpu_ops_asserts (
  .clk(clk), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord), .qPhase(qPhase),
  .instrTaken(instrTaken), .programCounter(programCounter), .workingAccumulator(workingAccumulator),
  .productHigh(productHigh), .productLow(productLow), .statusFlags(statusFlags),
  .returnStackTop(returnStackTop), .stackDepth(stackDepth), .callFill(callFill),
  .fileWriteStrobe(fileWriteStrobe), .fileWriteData(fileWriteData));
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the move, multiply, stack and call decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_ops_pkg::*;
  logic                clk, rstn, instrValid, loadEn, instrTaken, callFill, fileWriteStrobe;
  logic [15:0]         instrWord, prod;
  logic [BANK_W-1:0]   bankSelect;
  logic [ADDR_W-1:0]   loadAddr, fileWriteAddr;
  logic [7:0]          loadData, workingAccumulator, productHigh, productLow, fileWriteData, acc, r;
  logic [1:0]          qPhase;
  logic [PC_W-1:0]     programCounter, returnStackTop, pc;
  logic [FLAG_W-1:0]   statusFlags, flg;
  logic [4:0]          stackDepth;
  logic [PC_W-1:0]     stk[$];                  // Expected return stack, top at the end
  int                  err_count, cmp_count;
  // Negate cases: preload address, operand, instruction word (bank 3, access low, access high)
  localparam logic [11:0] NA[3] = '{12'h344, 12'h010, 12'hF90};
  localparam logic [7:0]  ND[3] = '{8'h3A, 8'h00, 8'hB0};
  localparam logic [15:0] NW[3] = '{16'h6D44, 16'h6C10, 16'h6C90};
  // Multiply-file words and the operand each one must reach
  localparam logic [15:0] MW[4] = '{16'h0355, 16'h0290, 16'h0344, 16'h0355};
  localparam logic [7:0]  MD[4] = '{8'hE2, 8'h50, 8'hC6, 8'hE2};
  cpu_move_mul_stack_call_ops u_cpu_move_mul_stack_call_ops (
    .clk(clk), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord), .bankSelect(bankSelect),
    .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .qPhase(qPhase), .instrTaken(instrTaken),
    .programCounter(programCounter), .workingAccumulator(workingAccumulator), .productHigh(productHigh),
    .productLow(productLow), .statusFlags(statusFlags), .returnStackTop(returnStackTop),
    .stackDepth(stackDepth), .callFill(callFill), .fileWriteStrobe(fileWriteStrobe),
    .fileWriteAddr(fileWriteAddr), .fileWriteData(fileWriteData));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  // Bounded wait on falling edges until the phase counter shows ph
  task automatic wait_phase(input logic [1:0] ph);
    for (int n = 0; n < 12 && qPhase !== ph; n++) @(negedge clk);
    if (qPhase !== ph) begin
      err_count++;
      close_out();
    end
  endtask
  // Offer a word so that it is seen at a Q1 edge, then withdraw it
  task automatic issue(input logic [15:0] w);
    @(negedge clk);
    wait_phase(2'd3);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord  <= w;
    @(posedge clk);
    instrValid <= 1'b0;
  endtask
  // Issue, see the acknowledge, and stop once results have landed
  task automatic run(input logic [15:0] w);
    issue(w);
    @(negedge clk);
    chk(instrTaken, 1'b1);
    wait_phase(2'd0);
  endtask
  task automatic expect_state();
    chk(workingAccumulator, acc);
    chk({productHigh, productLow}, prod);
    chk(statusFlags, flg);
    chk(programCounter, pc);
    chk(stackDepth, stk.size());
    chk(returnStackTop, stk.size() > 0 ? stk[$] : '0);
  endtask
  // Write report lands with the results and stands for one cycle only
  task automatic wstrobe(input logic e, input logic [11:0] a, input logic [7:0] d);
    chk(fileWriteStrobe, e);
    if (e) chk({fileWriteAddr, fileWriteData}, {a, d});
  endtask
  // Relative call; a word offered in the idle second cycle must be ignored
  task automatic call_check(input logic [10:0] n);
    issue({5'b11011, n});
    repeat (3) @(posedge clk);
    instrValid <= 1'b1;
    instrWord  <= 16'h0E77;
    @(negedge clk);
    stk.push_back(pc + PC_STEP);
    pc = pc + PC_STEP + {{9{n[10]}}, n, 1'b0};
    expect_state();
    chk(callFill, 1'b1);
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
    chk(instrTaken, 1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(callFill, 1'b0);
    expect_state();
  endtask
  initial begin
    {rstn, instrValid, loadEn, instrWord, loadAddr, loadData} = '0;
    bankSelect = 4'h3;
    {acc, prod, flg, pc, err_count, cmp_count} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Preload the operands, one strobe per cycle
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {loadEn, loadAddr, loadData} <= {1'b1, NA[i], ND[i]};
    end
    @(posedge clk);
    loadEn <= 1'b0;
    @(negedge clk);
    expect_state();
    for (int i = 0; i < 3; i++) begin
      run(NW[i]);
      r = 8'h00 - ND[i];
      flg = {r[7], ND[i] == 8'h80, r == 8'h00, ND[i][3:0] == 4'h0, ND[i] == 8'h00};
      pc += PC_STEP;
      expect_state();
      wstrobe(1'b1, NA[i], r);
    end
    run(16'h0EE2);
    acc = 8'hE2;
    pc += PC_STEP;
    expect_state();
    wstrobe(1'b0, '0, '0);
    for (int k = 0; k < 2; k++) begin
      r = k == 0 ? 8'hC4 : 8'h00;
      run({8'h0D, r});
      prod = 16'(acc) * 16'(r);
      pc += PC_STEP;
      expect_state();
    end
    run(16'h6F55);
    pc += PC_STEP;
    expect_state();
    wstrobe(1'b1, 12'h355, 8'hE2);
    for (int i = 0; i < 4; i++) begin
      run(MW[i]);
      prod = 16'(acc) * 16'(MD[i]);
      pc += PC_STEP;
      expect_state();
      wstrobe(1'b0, '0, '0);
    end
    for (int i = 0; i < 2; i++) begin
      run(i == 0 ? OP_NOP_ZERO : 16'hF123);
      pc += PC_STEP;
      expect_state();
      wstrobe(1'b0, '0, '0);
    end
    for (int i = 0; i < 3; i++) begin
      run(i < 2 ? OP_PUSH : OP_POP);
      if (i < 2) stk.push_back(pc);
      else void'(stk.pop_back());
      pc += PC_STEP;
      expect_state();
    end
    call_check(11'h005);
    call_check(11'h7FD);
    close_out();
  end
endmodule
`default_nettype wire
